// ==== src/spr_pkg.sv ====
// shared constants and carrier types for the pin and host-port configuration bank
package spr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_CFG_OFS    = 8'h0C;
  localparam logic [7:0] HOST_CFG_OFS   = 8'h10;

  // ----------------------------------------------------------------
  // pin configuration fields: three bits per pin, from bit 0 upward
  // ----------------------------------------------------------------
  localparam int         PIN_FIELD_W    = 3;
  localparam int         PIN_FLAG_POS   = 0;
  localparam int         PIN_DRIVE_POS  = 1;
  localparam int         PIN_LEVEL_POS  = 2;
  localparam logic [2:0] FSEL_GP_IN     = 3'h0;
  localparam logic [2:0] FSEL_GP_OUT    = 3'h7;

  // ----------------------------------------------------------------
  // host port configuration fields and reset values
  // ----------------------------------------------------------------
  localparam int         ACK_DLY_LSB    = 8;
  localparam int         HW_ORDER_POS   = 2;
  localparam int         RW_OE_POS      = 1;
  localparam int         LOC_PRIO_POS   = 0;
  localparam logic [2:0] ACK_DLY_RST    = 3'h1;
  localparam logic       HW_ORDER_RST   = 1'h1;
  localparam logic       RW_OE_RST      = 1'h0;
  localparam logic       LOC_PRIO_RST   = 1'h0;
  localparam logic [2:0] ACK_DLY_FIRST  = 3'h3;

  // ----------------------------------------------------------------
  // timing: longest nominal release delay against the clock period
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         ACK_MAX_NS     = 10;
  localparam int         ACK_HOLD_RAW   = (ACK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         ACK_HOLD_CYC   = (ACK_HOLD_RAW < 1) ? 1 : ACK_HOLD_RAW;

  // ----------------------------------------------------------------
  // request carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;     // addr[1] selects the halfword
    logic [15:0] wdata;
  } spr_host_req_t;

  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } spr_loc_req_t;

  typedef enum logic [2:0] {
    ACK_IDLE    = 3'h1,
    ACK_ASSERT  = 3'h2,
    ACK_RELEASE = 3'h4
  } spr_ack_state_t;

endpackage

// ==== src/spr_regs.sv ====
// pin configuration and host port configuration register bank
`timescale 1ns/1ps

// Contract
// - each pin level bit reads the present pin level and ignores writes.
// - a pin set as general-purpose output drives its last written drive value.
// - a level change in either direction on a pin sets its change flag.
// - setting a change flag also sets the pin interrupt flag when that interrupt is enabled.
// - writing 1 clears a change flag until the next change, writing 0 leaves it alone.
// - reserved host port config bits ignore writes and read as zero.
// - the three-bit ack delay resets to 001, codes 000-010 add no delay, 011-111 add some.
// - with delay codes 011-111 the ack pin is driven inactive before its output driver is turned off; with 000-010 both happen together.
// - halfword order bit (reset 1) picks which quadlet half host address bit 1 reaches.
// - with the rw-as-oe bit set, the host rw pin serves as read data output enable.
// - with local priority set, the internal client wins a same-cycle collision.
// - with local priority clear, the host wins and sees no wait state.
// - writing 1 to a change flag also clears the matching pin interrupt flag.
// - function select 000 makes a pin an input and 111 an output from its drive bit.
module spr_regs
  import spr_pkg::*;
#(
  parameter int NPINS = 5
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // general-purpose pins
  input  wire logic [NPINS-1:0]      pin_in,
  output logic      [NPINS-1:0]      pin_out,
  output logic      [NPINS-1:0]      pin_oe_n,
  input  wire logic [NPINS-1:0][2:0] pin_function_select,
  // interrupt enables in, flags out
  input  wire logic [NPINS-1:0]      pin_int_enable,
  output logic      [NPINS-1:0]      pin_interrupt_flag,
  // host access port
  input  wire logic                  host_req,
  input  wire spr_host_req_t         host_cmd,
  output logic                       host_grant,
  output logic                       host_wait,
  output logic                       host_done,
  output logic      [15:0]           host_rdata,
  // host ack and data enable pins
  input  wire logic                  host_rw_pin,
  output logic                       host_ack_n,
  output logic                       host_ack_oe_n,
  output logic                       host_data_oe_n,
  // internal client port
  input  wire logic                  loc_req,
  input  wire spr_loc_req_t          loc_cmd,
  output logic                       loc_grant,
  output logic                       loc_done,
  output logic      [31:0]           loc_rdata
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (NPINS < 1 || NPINS * PIN_FIELD_W > 16) begin : g_bad_npins
    $error("NPINS must fit the lower halfword");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the host halfword lands in bits 31:16
  function automatic logic upper_half(input logic addr1, input logic order);
    return addr1 ^ order;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NPINS-1:0] sync1, sync2, prev_lvl, change;
  logic [NPINS-1:0] drive_value, change_flag;
  logic [2:0]       ack_release_delay;
  logic             host_halfword_order, rw_pin_as_read_oe, local_priority;
  logic             rw_s1, rw_s2, rd_active;
  logic [31:0]      pin_cfg_q, host_cfg_q, rd_q;
  logic             sel_host, hi_lane, wr_pin, wr_host, lo_lane;
  logic [7:0]       acc_addr;
  logic [31:0]      wr_data;
  logic [3:0]       hold_cnt;
  spr_ack_state_t   ack_state, next_ack_state;

  // pin inputs and the host rw pin through two flops each
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1    <= '0;
      sync2    <= '0;
      prev_lvl <= '0;
      rw_s1    <= 1'b0;
      rw_s2    <= 1'b0;
    end else begin
      sync1    <= pin_in;
      sync2    <= sync1;
      prev_lvl <= sync2;
      rw_s1    <= host_rw_pin;
      rw_s2    <= rw_s1;
    end
  end

  assign change = sync2 ^ prev_lvl;

  // ----------------------------------------------------------------
  // arbitration: one access per cycle, loser is held off
  // ----------------------------------------------------------------
  always_comb begin
    host_grant = host_req & (~loc_req | ~local_priority);
    loc_grant  = loc_req & ~host_grant;
    host_wait  = host_req & ~host_grant;
    sel_host   = host_grant;
    // halfword select is not part of the register address
    acc_addr   = {sel_host ? host_cmd.addr[7:2] : loc_cmd.addr[7:2], 2'b00};
    hi_lane    = upper_half(host_cmd.addr[1], host_halfword_order);
    // host writes touch one half only; the other half sees zeros
    if (sel_host) begin
      wr_data = hi_lane ? {host_cmd.wdata, 16'h0000} : {16'h0000, host_cmd.wdata};
      lo_lane = ~hi_lane;
    end else begin
      wr_data = loc_cmd.wdata;
      lo_lane = 1'b1;
    end
    wr_pin  = (host_grant & host_cmd.we | loc_grant & loc_cmd.we) & lo_lane
              & (acc_addr == PIN_CFG_OFS);
    wr_host = (host_grant & host_cmd.we | loc_grant & loc_cmd.we) & lo_lane
              & (acc_addr == HOST_CFG_OFS);
  end

  // ----------------------------------------------------------------
  // pin register fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive_value        <= '0;
      change_flag        <= '0;
      pin_interrupt_flag <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (wr_pin) begin
          drive_value[i] <= wr_data[i*PIN_FIELD_W+PIN_DRIVE_POS];
        end
        // set beats clear when both land together
        change_flag[i] <= (change_flag[i] & ~(wr_pin & wr_data[i*PIN_FIELD_W+PIN_FLAG_POS]))
                          | change[i];
        pin_interrupt_flag[i] <= (pin_interrupt_flag[i]
                                  & ~(wr_pin & wr_data[i*PIN_FIELD_W+PIN_FLAG_POS]))
                                 | (change[i] & pin_int_enable[i]);
      end
    end
  end

  // pin drivers follow the function select
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pin_out[i]  = drive_value[i];
      pin_oe_n[i] = ~(pin_function_select[i] == FSEL_GP_OUT);
    end
  end

  // ----------------------------------------------------------------
  // host port configuration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_release_delay   <= ACK_DLY_RST;
      host_halfword_order <= HW_ORDER_RST;
      rw_pin_as_read_oe   <= RW_OE_RST;
      local_priority      <= LOC_PRIO_RST;
    end else if (wr_host) begin
      ack_release_delay   <= wr_data[ACK_DLY_LSB +: 3];
      host_halfword_order <= wr_data[HW_ORDER_POS];
      rw_pin_as_read_oe   <= wr_data[RW_OE_POS];
      local_priority      <= wr_data[LOC_PRIO_POS];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    pin_cfg_q = '0;
    for (int i = 0; i < NPINS; i++) begin
      pin_cfg_q[i*PIN_FIELD_W+PIN_LEVEL_POS] = sync2[i];
      pin_cfg_q[i*PIN_FIELD_W+PIN_DRIVE_POS] = drive_value[i];
      pin_cfg_q[i*PIN_FIELD_W+PIN_FLAG_POS]  = change_flag[i];
    end
    host_cfg_q = '0;
    host_cfg_q[ACK_DLY_LSB +: 3] = ack_release_delay;
    host_cfg_q[HW_ORDER_POS]     = host_halfword_order;
    host_cfg_q[RW_OE_POS]        = rw_pin_as_read_oe;
    host_cfg_q[LOC_PRIO_POS]     = local_priority;
    unique case (acc_addr)
      PIN_CFG_OFS:  rd_q = pin_cfg_q;
      HOST_CFG_OFS: rd_q = host_cfg_q;
      default:      rd_q = '0;   // unmapped reads as zero
    endcase
  end

  // answers one cycle after the grant
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      host_done  <= 1'b0;
      loc_done   <= 1'b0;
      host_rdata <= '0;
      loc_rdata  <= '0;
      rd_active  <= 1'b0;
    end else begin
      host_done <= host_grant;
      loc_done  <= loc_grant;
      if (host_grant) begin
        host_rdata <= hi_lane ? rd_q[31:16] : rd_q[15:0];
        rd_active  <= ~host_cmd.we;
      end else if (ack_state == ACK_IDLE) begin
        rd_active  <= 1'b0;
      end
      if (loc_grant) begin
        loc_rdata <= rd_q;
      end
    end
  end

  // read data enable: either the ack window or the host rw pin
  assign host_data_oe_n = rw_pin_as_read_oe ? ~(rd_active & rw_s2)
                                            : ~(rd_active & host_done);

  // ----------------------------------------------------------------
  // ack pin: assert, drive inactive for delay codes 011-111 only, then release the driver
  // ----------------------------------------------------------------
  always_comb begin
    next_ack_state = ack_state;
    unique case (ack_state)
      ACK_IDLE:    if (host_grant) next_ack_state = ACK_ASSERT;
      ACK_ASSERT:  next_ack_state = ACK_RELEASE;
      ACK_RELEASE: if (hold_cnt == 4'h0) next_ack_state = ACK_IDLE;
      default:     next_ack_state = ACK_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_state <= ACK_IDLE;
      hold_cnt  <= 4'h0;
    end else begin
      ack_state <= next_ack_state;
      // sub-period delays still need a whole cycle of inactive drive
      if (ack_state == ACK_ASSERT) begin
        hold_cnt <= (ack_release_delay >= ACK_DLY_FIRST) ? 4'(ACK_HOLD_CYC - 1) : 4'h0;
      end else if (hold_cnt != 4'h0) begin
        hold_cnt <= hold_cnt - 4'h1;
      end
    end
  end

  assign host_ack_n    = ~(ack_state == ACK_ASSERT);
  assign host_ack_oe_n = ~((ack_state == ACK_ASSERT) |
                           (ack_state == ACK_RELEASE &&
                            ack_release_delay >= ACK_DLY_FIRST));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ack_low;
    !host_ack_n && !host_ack_oe_n;
  endsequence
  sequence s_ack_high_driven;
    host_ack_n && !host_ack_oe_n;
  endsequence

  a_ack_release_order: assert property (@(posedge mclk) disable iff (!rst_b)
    s_ack_low ##1 (ack_release_delay >= ACK_DLY_FIRST) |-> s_ack_high_driven)
    else $error("ack driver released before driving inactive");
  a_ack_no_delay: assert property (@(posedge mclk) disable iff (!rst_b)
    !host_ack_n && ack_release_delay < ACK_DLY_FIRST |=> host_ack_oe_n)
    else $error("ack driver held with no delay code");
  a_ack_after_grant: assert property (@(posedge mclk) disable iff (!rst_b)
    host_grant && ack_state == ACK_IDLE |=> !host_ack_n ##1 host_ack_n)
    else $error("ack pulse missing after host grant");
  a_host_wins_tie: assert property (@(posedge mclk) disable iff (!rst_b)
    host_req && loc_req && !local_priority |-> host_grant && !loc_grant && !host_wait)
    else $error("host lost a tie without local priority");
  a_local_wins_tie: assert property (@(posedge mclk) disable iff (!rst_b)
    host_req && loc_req && local_priority |-> loc_grant && host_wait)
    else $error("internal client lost a tie with local priority");
  a_flag_on_change: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(sync2) |=> ((change_flag & $past(sync2 ^ prev_lvl)) == $past(sync2 ^ prev_lvl)))
    else $error("change flag not set on pin change");
  a_flag_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_pin && change[0] && wr_data[PIN_FLAG_POS] |=> change_flag[0])
    else $error("clear beat a same-cycle change");
  a_flag_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_pin && wr_data[PIN_FLAG_POS] && !change[0] |=> !change_flag[0])
    else $error("change flag not cleared by write of one");
  a_int_follows_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    change[0] && pin_int_enable[0] |=> pin_interrupt_flag[0] && change_flag[0])
    else $error("interrupt flag not set with change flag");
  a_int_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_pin && wr_data[PIN_FLAG_POS] && !change[0] |=> !pin_interrupt_flag[0])
    else $error("interrupt flag not cleared");
  a_level_reads_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    host_grant && !host_cmd.we && acc_addr == PIN_CFG_OFS && !hi_lane
    |=> host_rdata[PIN_LEVEL_POS] == $past(sync2[0]))
    else $error("level bit does not show the pin");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    host_cfg_q[31:11] == 21'h0 && host_cfg_q[7:3] == 5'h0)
    else $error("reserved host config bits not zero");
  a_drive_pin: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_pin && pin_function_select[0] == FSEL_GP_OUT ##1 pin_function_select[0] == FSEL_GP_OUT
    |-> !pin_oe_n[0] && pin_out[0] == $past(wr_data[PIN_DRIVE_POS]))
    else $error("output pin does not drive written value");

endmodule

// ==== verification/spr_host_model.sv ====
// host microcontroller model for the host access port of the register bank
`timescale 1ns/1ps
module spr_host_model
  import spr_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // request side
  output logic             host_req,
  output spr_host_req_t    host_cmd,
  output logic             host_rw_pin,
  // answer side
  input  wire logic        host_grant,
  input  wire logic        host_done,
  input  wire logic [15:0] host_rdata,
  input  wire logic        host_ack_n,
  input  wire logic        host_ack_oe_n,
  input  wire logic        host_data_oe_n
);
  // ----------------------------------------------------------------
  // idle bus
  // ----------------------------------------------------------------
  initial begin
    host_req = 1'b0;
    host_cmd = '0;
    host_rw_pin = 1'b0;
  end

  // rw strobe level, used as read enable by split-strobe hosts
  task automatic set_rw(input logic v);
    host_rw_pin = v;
  endtask

  // ----------------------------------------------------------------
  // one access: held until the granting edge, then the bus is scrambled
  // ----------------------------------------------------------------
  task automatic access(input logic we, input logic [7:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic [5:0] ack_seq,
                        output logic doe_n, output logic ok);
    logic g;
    int   n;
    g = 1'b0;
    n = 0;
    host_req = 1'b1;
    host_cmd = '{we, addr, wdata};
    while (!g && n < 20) begin
      @(negedge mclk);
      g = (host_grant === 1'b1);
      @(posedge mclk);
      #1;
      n++;
    end
    host_req = 1'b0;
    host_cmd = ~host_cmd;  // released lines show no stale value
    rdata = host_rdata;
    doe_n = host_data_oe_n;
    ok = g && (host_done === 1'b1);
    ack_seq[5:4] = {host_ack_n, host_ack_oe_n};
    @(posedge mclk);
    #1;
    ack_seq[3:2] = {host_ack_n, host_ack_oe_n};
    @(posedge mclk);
    #1;
    ack_seq[1:0] = {host_ack_n, host_ack_oe_n};
  endtask
endmodule

// ==== verification/test_sysconfig_pin_and_host_port_regs.sv ====
// self-checking bench for the pin and host port configuration bank
`timescale 1ns/1ps
module test_sysconfig_pin_and_host_port_regs
  import spr_pkg::*;
();
  logic mclk, rst_b, host_req, host_grant, host_wait, host_done, host_rw_pin;
  logic host_ack_n, host_ack_oe_n, host_data_oe_n, loc_req, loc_grant, loc_done;
  logic [4:0]      pin_in, pin_out, pin_oe_n, int_en, int_flag;
  logic [4:0][2:0] fsel;
  logic [15:0]     host_rdata, h_rdata;
  logic [31:0]     loc_rdata, r;
  logic [5:0]      h_ack;
  logic            h_doe, h_ok;
  spr_host_req_t   host_cmd;
  spr_loc_req_t    loc_cmd;
  int              err_count, compares;

  spr_regs #(.NPINS(5)) spr_regs_i (
    .mclk(mclk), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_function_select(fsel), .pin_int_enable(int_en),
    .pin_interrupt_flag(int_flag), .host_req(host_req), .host_cmd(host_cmd),
    .host_grant(host_grant), .host_wait(host_wait), .host_done(host_done),
    .host_rdata(host_rdata), .host_rw_pin(host_rw_pin), .host_ack_n(host_ack_n),
    .host_ack_oe_n(host_ack_oe_n), .host_data_oe_n(host_data_oe_n),
    .loc_req(loc_req), .loc_cmd(loc_cmd), .loc_grant(loc_grant),
    .loc_done(loc_done), .loc_rdata(loc_rdata));

  spr_host_model spr_host_model_i (
    .mclk(mclk), .host_req(host_req), .host_cmd(host_cmd), .host_rw_pin(host_rw_pin),
    .host_grant(host_grant), .host_done(host_done), .host_rdata(host_rdata),
    .host_ack_n(host_ack_n), .host_ack_oe_n(host_ack_oe_n),
    .host_data_oe_n(host_data_oe_n));

  // ----------------------------------------------------------------
  // report helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // access tasks; a lost grant ends the run rather than hanging
  // ----------------------------------------------------------------
  task automatic loc_acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    logic g;
    int   n;
    g = 1'b0;
    n = 0;
    loc_req = 1'b1;
    loc_cmd = '{we, a, d};
    while (!g && n < 20) begin
      @(negedge mclk);
      g = (loc_grant === 1'b1);
      @(posedge mclk);
      #1;
      n++;
    end
    loc_req = 1'b0;
    loc_cmd = ~loc_cmd;
    rd = loc_rdata;
    if (!g || loc_done !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    @(posedge mclk);
    #1;
  endtask

  task automatic lw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    loc_acc(1'b1, a, d, rd);
  endtask

  task automatic lr(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    loc_acc(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic host_acc(input logic we, input logic [7:0] a, input logic [15:0] d);
    spr_host_model_i.access(we, a, d, h_rdata, h_ack, h_doe, h_ok);
    if (!h_ok) begin
      err_count++;
      wrap_up();
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, pin_in, fsel, loc_req, loc_cmd} = '0;
    int_en = 5'h05;
    err_count = 0;
    compares = 0;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    lr(HOST_CFG_OFS, 32'h0000_0104);
    lw(HOST_CFG_OFS, 32'hFFFF_FFFF);
    lr(HOST_CFG_OFS, 32'h0000_0707);
    lr(8'h20, 32'h0);
    // every delay code; sub-period delays still cost one inactive cycle
    for (int c = 0; c < 8; c++) begin
      host_acc(1'b1, 8'h12, {5'h0, 3'(c), 8'h04});
      host_acc(1'b0, 8'h12, 16'h0);
      chk(32'(h_rdata), {21'h0, 3'(c), 8'h04});
      chk(32'(h_ack), (c >= 3) ? 32'h0B : 32'h0F);
      chk(32'(h_doe), 32'h0);
    end
    host_acc(1'b1, 8'h12, 16'h0100);
    host_acc(1'b0, 8'h10, 16'h0);
    chk(32'(h_rdata), 32'h0100);
    host_acc(1'b0, 8'h12, 16'h0);
    chk(32'(h_rdata), 32'h0);
    host_acc(1'b1, 8'h12, 16'hFFFF);
    lr(HOST_CFG_OFS, 32'h0000_0100);
    lw(HOST_CFG_OFS, 32'h0000_0106);
    host_acc(1'b0, 8'h12, 16'h0);
    chk(32'(h_doe), 32'h1);
    spr_host_model_i.set_rw(1'b1);
    repeat (3) @(posedge mclk);
    #1;
    host_acc(1'b0, 8'h12, 16'h0);
    chk(32'(h_doe), 32'h0);
    spr_host_model_i.set_rw(1'b0);
    // same-cycle collision under both priority settings
    for (int p = 0; p < 2; p++) begin
      lw(HOST_CFG_OFS, 32'h0000_0104 | 32'(p));
      fork
        host_acc(1'b0, 8'h12, 16'h0);
        loc_acc(1'b0, HOST_CFG_OFS, 32'h0, r);
        begin
          @(negedge mclk);
          chk({29'h0, host_grant, loc_grant, host_wait}, p ? 32'h3 : 32'h4);
        end
      join
    end
    // pins as outputs, then input levels, change flags and interrupts
    fsel = {5{FSEL_GP_OUT}};
    lw(PIN_CFG_OFS, 32'h2492);
    chk({22'h0, pin_oe_n, pin_out}, 32'h01F);
    pin_in = 5'h15;
    repeat (6) @(posedge mclk);
    #1;
    lr(PIN_CFG_OFS, 32'h75D7);
    chk(32'(int_flag), 32'h05);
    lw(PIN_CFG_OFS, 32'h24B3);
    lr(PIN_CFG_OFS, 32'h75D6);
    chk(32'(int_flag), 32'h04);
    lw(PIN_CFG_OFS, 32'h2492);
    lr(PIN_CFG_OFS, 32'h75D6);
    pin_in = 5'h14;
    fsel = '0;
    repeat (6) @(posedge mclk);
    #1;
    lr(PIN_CFG_OFS, 32'h75D3);
    chk({22'h0, pin_oe_n, int_flag}, 32'h3E5);
    // clearing write taken on the very edge that registers a new change
    pin_in = 5'h15;
    repeat (2) @(posedge mclk);
    #1;
    lw(PIN_CFG_OFS, 32'h2493);
    lr(PIN_CFG_OFS, 32'h75D7);
    chk(32'(int_flag), 32'h05);
    host_acc(1'b0, 8'h0E, 16'h0);
    chk(32'(h_rdata), 32'h75D7);
    // second reset in mid-run restores the defaults
    rst_b = 1'b0;
    @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk({30'h0, host_ack_n, host_ack_oe_n}, 32'h3);
    lr(HOST_CFG_OFS, 32'h0000_0104);
    wrap_up();
  end
endmodule
